// ### hw/idec_pkg.sv
/*
 Shared constants of the terminal function decoder.
 Assumes a 32-bit AXI4-Lite bus with 8-bit byte addresses.
*/
package idec_pkg;
	// Sizes
	localparam int NUM_TERM = 9;
	localparam int FUNC_W = 6;
	localparam int NUM_FUNC = 36;
	localparam int FREQ_W = 16;
	localparam int NUM_PRESET = 15;
	localparam int PIDX_W = 4;
	localparam int ADDR_W = 8;

	// Terminal function codes
	localparam logic [5:0] FN_PRESET_SEL_BIT0 = 6'h00;
	localparam logic [5:0] FN_PRESET_SEL_BIT1 = 6'h01;
	localparam logic [5:0] FN_PRESET_SEL_BIT2 = 6'h02;
	localparam logic [5:0] FN_PRESET_SEL_BIT3 = 6'h03;
	localparam logic [5:0] FN_RAMP_SEL_LOW = 6'h04;
	localparam logic [5:0] FN_RAMP_SEL_HIGH = 6'h05;
	localparam logic [5:0] FN_RUN_SELF_HOLD = 6'h06;
	localparam logic [5:0] FN_COAST_STOP = 6'h07;
	localparam logic [5:0] FN_ALARM_RESET = 6'h08;
	localparam logic [5:0] FN_EXTERNAL_FAULT = 6'h09;
	localparam logic [5:0] FN_FREQ_SOURCE_SWITCH = 6'h0B;
	localparam logic [5:0] FN_FREQ_SOURCE_SWITCH_INV = 6'h23;

	// Reset values; a code above 35 selects no function
	localparam logic [5:0] FUNC_RESET = 6'h3F;
	localparam logic [15:0] FREQ_RESET = 16'h0000;

	// Register byte offsets
	localparam logic [7:0] OFS_TERM_FUNC_FIRST = 8'h00;
	localparam logic [7:0] OFS_TERM_FUNC_LAST = 8'h20;
	localparam logic [7:0] OFS_PRIMARY_FREQ = 8'h24;
	localparam logic [7:0] OFS_ALT_FREQ = 8'h28;
	localparam logic [7:0] OFS_PRESET_FIRST = 8'h40;
	localparam logic [7:0] OFS_PRESET_LAST = 8'h78;
	localparam logic [7:0] OFS_CMD_LO = 8'h80;
	localparam logic [7:0] OFS_CMD_HI = 8'h84;
	localparam logic [7:0] OFS_DRIVE_STAT = 8'h88;
	localparam logic [7:0] OFS_TERM_STAT = 8'h8C;

	// Drive status bit positions
	localparam int ST_RAMP_LSB = 16;
	localparam int ST_RUN_FWD = 18;
	localparam int ST_RUN_BWD = 19;
	localparam int ST_CUTOFF = 20;
	localparam int ST_ALARM = 21;
	localparam int ST_TRIP = 22;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} idec_rd_state_t;
endpackage

// ### hw/idec_preset_mem.sv
/*
 Preset frequency store: one write port, two registered read ports.
 Assumes addresses at or above DEPTH read as zero and are never written.
*/
`timescale 1ns/1ns
module idec_preset_mem #(
	parameter int DEPTH = 15,
	parameter int AW = 4,
	parameter int DW = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Write port
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire logic [DW-1:0] wdata_in,
	// Read ports, data one cycle after address
	input wire logic [AW-1:0] raddr_a_in,
	output logic [DW-1:0] q_a_out,
	input wire logic [AW-1:0] raddr_b_in,
	output logic [DW-1:0] q_b_out
);
	logic [DW-1:0] mem_reg [DEPTH];
	logic [DW-1:0] mem_next [DEPTH];
	logic [DW-1:0] q_a_reg, q_a_next, q_b_reg, q_b_next;

	// Out-of-range reads give zero rather than an undefined word
	always_comb begin
		mem_next = mem_reg;
		if (we_in && (int'(waddr_in) < DEPTH)) begin
			mem_next[waddr_in] = wdata_in;
		end
		q_a_next = (int'(raddr_a_in) < DEPTH) ? mem_reg[raddr_a_in] : '0;
		q_b_next = (int'(raddr_b_in) < DEPTH) ? mem_reg[raddr_b_in] : '0;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mem_reg <= '{default: '0};
			q_a_reg <= '0;
			q_b_reg <= '0;
		end else begin
			mem_reg <= mem_next;
			q_a_reg <= q_a_next;
			q_b_reg <= q_b_next;
		end
	end

	assign q_a_out = q_a_reg;
	assign q_b_out = q_b_reg;
endmodule // idec_preset_mem

// ### hw/idec_sync.sv
/*
 Two-stage synchroniser for a group of asynchronous level inputs.
 Assumes each bit changes slowly against the clock; bits are not coherent.
*/
`timescale 1ns/1ns
module idec_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Levels
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg, meta_next, sync_reg, sync_next;

	// The first stage feeds only the second stage
	always_comb begin
		meta_next = d_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign q_out = sync_reg;
endmodule // idec_sync

// ### hw/idec_top.sv
/*
 Terminal function decoder: nine configurable inputs to drive commands.
 Assumes asynchronous contact pins, high when closed; TRIP_IN on this clock.
*/
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
// Behaviour
// - Nine terminals, each with a function setting
// - Codes 0-3 give preset bits 1,2,4,8
// - Codes 4,5 give ramp select low, high
// - Codes 11-14 source, motor, brake, torque
// - Codes 15,16 switchover; 17,18 speed up/down
// - Codes 19-21 edit, PID cancel, analog invert
// - Codes 22-26 interlock through start characteristic
// - Codes 27,28,29,32 encoder option commands
// - Codes 30,31 forced halt, halt on ramp4
// - Codes 33-35 line speed and inverse switch
// - Unassigned function codes stay inactive
// - Nonzero preset index selects stored preset
// - Ramp bits pick one of four time pairs
// - Self-hold latches run; release drops it
// - Coast cuts output, no alarm, restarts
// - Reset on clears alarm, release clears trip
module idec_top (
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	// Terminal and run pins, asynchronous
	input wire logic [idec_pkg::NUM_TERM-1:0] TERM_IN,
	input wire logic RUN_FORWARD_IN,
	input wire logic RUN_BACKWARD_IN,
	// Trip request from protection logic, same clock
	input wire logic TRIP_IN,
	// AXI4-Lite write channels
	input wire logic [idec_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	// AXI4-Lite read channels
	input wire logic [idec_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	// Decoded commands and drive controls
	output logic [idec_pkg::NUM_FUNC-1:0] CMD_FLAGS_OUT,
	output logic [idec_pkg::FREQ_W-1:0] SPEED_REF_OUT,
	output logic [1:0] RAMP_SEL_OUT,
	output logic RUN_FORWARD_OUT,
	output logic RUN_BACKWARD_OUT,
	output logic OUTPUT_CUTOFF_OUT,
	output logic RESTART_START_FREQ_OUT,
	output logic ALARM_OUT,
	output logic TRIP_IND_OUT
);
	import idec_pkg::*;

	logic [NUM_TERM+1:0] pins_s;
	logic [NUM_TERM-1:0] term_s;
	logic fwd_s, bwd_s;

	// Pins are brought into the clock domain before any decode
	idec_sync #(.W(NUM_TERM + 2)) u_sync (
		.clk_in(CLK_SYS_IN),
		.rst_in(RST_IN),
		.d_in({RUN_BACKWARD_IN, RUN_FORWARD_IN, TERM_IN}),
		.q_out(pins_s)
	);
	assign term_s = pins_s[NUM_TERM-1:0];
	assign fwd_s = pins_s[NUM_TERM];
	assign bwd_s = pins_s[NUM_TERM+1];

	// Configuration and write channel state
	logic [FUNC_W-1:0] term_func_reg [NUM_TERM];
	logic [FUNC_W-1:0] term_func_next [NUM_TERM];
	logic [FREQ_W-1:0] pri_freq_reg, pri_freq_next, alt_freq_reg, alt_freq_next;
	logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic [ADDR_W-1:0] waddr_reg, waddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic mem_we;
	logic [PIDX_W-1:0] mem_waddr;
	logic [FREQ_W-1:0] mem_wdata;

	// Read channel state
	idec_rd_state_t rd_state_reg, rd_state_next;
	logic [ADDR_W-1:0] raddr_reg, raddr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [PIDX_W-1:0] mem_bus_addr;
	logic [FREQ_W-1:0] mem_bus_q;

	// Decode and drive state
	logic [NUM_FUNC-1:0] cmd_flags_reg, cmd_flags_next, assigned_reg, assigned_next;
	logic [PIDX_W-1:0] preset_idx_reg, preset_idx_next;
	logic alt_sel_reg, alt_sel_next;
	logic [FREQ_W-1:0] mem_spd_q;
	logic [FREQ_W-1:0] speed_ref_reg, speed_ref_next;
	logic [1:0] ramp_reg, ramp_next;
	logic latch_fwd_reg, latch_fwd_next, latch_bwd_reg, latch_bwd_next;
	logic run_fwd_reg, run_fwd_next, run_bwd_reg, run_bwd_next;
	logic coast_d_reg, coast_d_next, alarm_rst_d_reg, alarm_rst_d_next;
	logic trip_reg, trip_next, alarm_reg, alarm_next;
	logic cutoff_reg, cutoff_next, restart_reg, restart_next;

	// Byte-lane merge for the 16-bit frequency registers
	function automatic logic [15:0] merge_lanes(input logic [15:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [15:0] res;
		res = old_v;
		if (strb[0]) begin
			res[7:0] = new_v[7:0];
		end
		if (strb[1]) begin
			res[15:8] = new_v[15:8];
		end
		return res;
	endfunction

	// Write path: address and data are taken in either order, then answered
	always_comb begin
		logic [ADDR_W-1:0] wa;
		wa = '0;
		aw_got_next = aw_got_reg | (S_AXI_AWVALID_IN & awready_reg);
		w_got_next = w_got_reg | (S_AXI_WVALID_IN & wready_reg);
		waddr_next = (S_AXI_AWVALID_IN & awready_reg) ? S_AXI_AWADDR_IN : waddr_reg;
		wdata_next = (S_AXI_WVALID_IN & wready_reg) ? S_AXI_WDATA_IN : wdata_reg;
		wstrb_next = (S_AXI_WVALID_IN & wready_reg) ? S_AXI_WSTRB_IN : wstrb_reg;
		bvalid_next = bvalid_reg & ~S_AXI_BREADY_IN;
		bresp_next = bresp_reg;
		term_func_next = term_func_reg;
		pri_freq_next = pri_freq_reg;
		alt_freq_next = alt_freq_reg;
		mem_we = 1'b0;
		mem_waddr = waddr_next[5:2];
		mem_wdata = wdata_next[FREQ_W-1:0];
		wa = {waddr_next[ADDR_W-1:2], 2'h0};
		if (aw_got_next && w_got_next && !bvalid_reg) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			if (wa <= OFS_TERM_FUNC_LAST) begin
				if (wstrb_next[0]) begin
					term_func_next[wa[5:2]] = wdata_next[FUNC_W-1:0];
				end
			end else if (wa == OFS_PRIMARY_FREQ) begin
				pri_freq_next = merge_lanes(pri_freq_reg, wdata_next, wstrb_next);
			end else if (wa == OFS_ALT_FREQ) begin
				alt_freq_next = merge_lanes(alt_freq_reg, wdata_next, wstrb_next);
			end else if (wa >= OFS_PRESET_FIRST && wa <= OFS_PRESET_LAST) begin
				// Memory has no read-modify-write, so a partial word is dropped
				mem_we = (wstrb_next[1:0] == 2'h3);
			end else if (wa >= OFS_CMD_LO && wa <= OFS_TERM_STAT) begin
				bresp_next = RESP_OKAY; // Status words ignore writes
			end else begin
				bresp_next = RESP_SLVERR;
			end
		end
		awready_next = ~aw_got_next & ~bvalid_next;
		wready_next = ~w_got_next & ~bvalid_next;
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			term_func_reg <= '{default: FUNC_RESET};
			pri_freq_reg <= FREQ_RESET;
			alt_freq_reg <= FREQ_RESET;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			term_func_reg <= term_func_next;
			pri_freq_reg <= pri_freq_next;
			alt_freq_reg <= alt_freq_next;
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
		end
	end

	// Read path: one wait cycle lets the preset store answer from a register
	always_comb begin
		logic [ADDR_W-1:0] ra;
		ra = {raddr_reg[ADDR_W-1:2], 2'h0};
		rd_state_next = rd_state_reg;
		raddr_next = raddr_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		mem_bus_addr = raddr_reg[5:2];
		case (rd_state_reg)
			RD_IDLE: begin
				if (S_AXI_ARVALID_IN && arready_reg) begin
					raddr_next = S_AXI_ARADDR_IN;
					mem_bus_addr = S_AXI_ARADDR_IN[5:2];
					rd_state_next = RD_WAIT;
				end
			end
			RD_WAIT: begin
				rd_state_next = RD_RESP;
				rresp_next = RESP_OKAY;
				rdata_next = '0;
				if (ra <= OFS_TERM_FUNC_LAST) begin
					rdata_next[FUNC_W-1:0] = term_func_reg[ra[5:2]];
				end else if (ra == OFS_PRIMARY_FREQ) begin
					rdata_next[FREQ_W-1:0] = pri_freq_reg;
				end else if (ra == OFS_ALT_FREQ) begin
					rdata_next[FREQ_W-1:0] = alt_freq_reg;
				end else if (ra >= OFS_PRESET_FIRST && ra <= OFS_PRESET_LAST) begin
					rdata_next[FREQ_W-1:0] = mem_bus_q;
				end else if (ra == OFS_CMD_LO) begin
					rdata_next = cmd_flags_reg[31:0];
				end else if (ra == OFS_CMD_HI) begin
					rdata_next[NUM_FUNC-33:0] = cmd_flags_reg[NUM_FUNC-1:32];
				end else if (ra == OFS_DRIVE_STAT) begin
					rdata_next[FREQ_W-1:0] = speed_ref_reg;
					rdata_next[ST_RAMP_LSB +: 2] = ramp_reg;
					rdata_next[ST_RUN_FWD] = run_fwd_reg;
					rdata_next[ST_RUN_BWD] = run_bwd_reg;
					rdata_next[ST_CUTOFF] = cutoff_reg;
					rdata_next[ST_ALARM] = alarm_reg;
					rdata_next[ST_TRIP] = trip_reg;
				end else if (ra == OFS_TERM_STAT) begin
					rdata_next[NUM_TERM+1:0] = pins_s;
				end else begin
					rresp_next = RESP_SLVERR;
				end
			end
			RD_RESP: begin
				if (S_AXI_RREADY_IN) begin
					rd_state_next = RD_IDLE;
				end
			end
			default: begin
				rd_state_next = RD_IDLE;
			end
		endcase
		arready_next = (rd_state_next == RD_IDLE);
		rvalid_next = (rd_state_next == RD_RESP);
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			rd_state_reg <= RD_IDLE;
			raddr_reg <= '0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
		end else begin
			rd_state_reg <= rd_state_next;
			raddr_reg <= raddr_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Preset store: port a feeds the speed path, port b the bus
	idec_preset_mem #(.DEPTH(NUM_PRESET), .AW(PIDX_W), .DW(FREQ_W)) u_mem (
		.clk_in(CLK_SYS_IN),
		.rst_in(RST_IN),
		.we_in(mem_we),
		.waddr_in(mem_waddr),
		.wdata_in(mem_wdata),
		.raddr_a_in(preset_idx_next - 4'h1),
		.q_a_out(mem_spd_q),
		.raddr_b_in(mem_bus_addr),
		.q_b_out(mem_bus_q)
	);

	// Every code is compared against every terminal, so duplicates simply OR
	always_comb begin
		cmd_flags_next = '0;
		assigned_next = '0;
		for (int f = 0; f < NUM_FUNC; f++) begin
			for (int t = 0; t < NUM_TERM; t++) begin
				if (term_func_reg[t] == FUNC_W'(f)) begin
					assigned_next[f] = 1'b1;
					cmd_flags_next[f] = cmd_flags_next[f] | term_s[t];
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			cmd_flags_reg <= '0;
			assigned_reg <= '0;
		end else begin
			cmd_flags_reg <= cmd_flags_next;
			assigned_reg <= assigned_next;
		end
	end

	// Speed, ramp, run hold, coast and alarm handling
	always_comb begin
		logic fwd_req, bwd_req, hold_on, coast, alarm_rst, trip_set;
		fwd_req = fwd_s & ~bwd_s; // Both run inputs on means stop unless self-hold keeps a latched run
		bwd_req = bwd_s & ~fwd_s;
		hold_on = cmd_flags_reg[FN_RUN_SELF_HOLD];
		coast = cmd_flags_reg[FN_COAST_STOP];
		alarm_rst = cmd_flags_reg[FN_ALARM_RESET];
		// External fault trips when its contact opens, only if assigned
		trip_set = TRIP_IN | (assigned_reg[FN_EXTERNAL_FAULT] & ~cmd_flags_reg[FN_EXTERNAL_FAULT]);
		preset_idx_next = {cmd_flags_reg[FN_PRESET_SEL_BIT3], cmd_flags_reg[FN_PRESET_SEL_BIT2],
			cmd_flags_reg[FN_PRESET_SEL_BIT1], cmd_flags_reg[FN_PRESET_SEL_BIT0]};
		alt_sel_next = cmd_flags_reg[FN_FREQ_SOURCE_SWITCH] |
			(assigned_reg[FN_FREQ_SOURCE_SWITCH_INV] & ~cmd_flags_reg[FN_FREQ_SOURCE_SWITCH_INV]);
		if (preset_idx_reg != '0) begin
			speed_ref_next = mem_spd_q;
		end else begin
			speed_ref_next = alt_sel_reg ? alt_freq_reg : pri_freq_reg;
		end
		ramp_next = {cmd_flags_reg[FN_RAMP_SEL_HIGH], cmd_flags_reg[FN_RAMP_SEL_LOW]};
		// Without hold the latch just follows the run inputs
		latch_fwd_next = fwd_req | (hold_on & latch_fwd_reg & ~bwd_req);
		latch_bwd_next = bwd_req | (hold_on & latch_bwd_reg & ~fwd_req);
		coast_d_next = coast;
		alarm_rst_d_next = alarm_rst;
		// New trip wins over the release that would clear it
		trip_next = trip_set | (trip_reg & ~(alarm_rst_d_reg & ~alarm_rst));
		alarm_next = trip_set | (alarm_reg & ~alarm_rst);
		cutoff_next = coast | trip_reg;
		restart_next = coast_d_reg & ~coast & (latch_fwd_reg | latch_bwd_reg) & ~trip_reg;
		run_fwd_next = latch_fwd_reg & ~coast & ~trip_reg;
		run_bwd_next = latch_bwd_reg & ~coast & ~trip_reg;
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			preset_idx_reg <= '0;
			alt_sel_reg <= 1'b0;
			speed_ref_reg <= FREQ_RESET;
			ramp_reg <= 2'h0;
			latch_fwd_reg <= 1'b0;
			latch_bwd_reg <= 1'b0;
			coast_d_reg <= 1'b0;
			alarm_rst_d_reg <= 1'b0;
			trip_reg <= 1'b0;
			alarm_reg <= 1'b0;
			cutoff_reg <= 1'b0;
			restart_reg <= 1'b0;
			run_fwd_reg <= 1'b0;
			run_bwd_reg <= 1'b0;
		end else begin
			preset_idx_reg <= preset_idx_next;
			alt_sel_reg <= alt_sel_next;
			speed_ref_reg <= speed_ref_next;
			ramp_reg <= ramp_next;
			latch_fwd_reg <= latch_fwd_next;
			latch_bwd_reg <= latch_bwd_next;
			coast_d_reg <= coast_d_next;
			alarm_rst_d_reg <= alarm_rst_d_next;
			trip_reg <= trip_next;
			alarm_reg <= alarm_next;
			cutoff_reg <= cutoff_next;
			restart_reg <= restart_next;
			run_fwd_reg <= run_fwd_next;
			run_bwd_reg <= run_bwd_next;
		end
	end

	// All outputs come straight from registers
	assign S_AXI_AWREADY_OUT = awready_reg;
	assign S_AXI_WREADY_OUT = wready_reg;
	assign S_AXI_BRESP_OUT = bresp_reg;
	assign S_AXI_BVALID_OUT = bvalid_reg;
	assign S_AXI_ARREADY_OUT = arready_reg;
	assign S_AXI_RDATA_OUT = rdata_reg;
	assign S_AXI_RRESP_OUT = rresp_reg;
	assign S_AXI_RVALID_OUT = rvalid_reg;
	assign CMD_FLAGS_OUT = cmd_flags_reg;
	assign SPEED_REF_OUT = speed_ref_reg;
	assign RAMP_SEL_OUT = ramp_reg;
	assign RUN_FORWARD_OUT = run_fwd_reg;
	assign RUN_BACKWARD_OUT = run_bwd_reg;
	assign OUTPUT_CUTOFF_OUT = cutoff_reg;
	assign RESTART_START_FREQ_OUT = restart_reg;
	assign ALARM_OUT = alarm_reg;
	assign TRIP_IND_OUT = trip_reg;
endmodule // idec_top

// ### verif/idec_contacts.sv
/*
 Contact model: terminal and run contacts to the input common.
 Assumes wanted states from the bench; pins move 1 ns later.
*/
`timescale 1ns/1ns
module idec_contacts (
	// Wanted states
	input wire logic [8:0] want_term_in,
	input wire logic want_fwd_in,
	input wire logic want_bwd_in,
	// Pin levels, all open at power-up
	output logic [8:0] term_out = 9'h000,
	output logic fwd_out = 1'b0,
	output logic bwd_out = 1'b0
);
	// Contacts are asynchronous, so they never switch on a sampling edge
	always @(want_term_in, want_fwd_in, want_bwd_in) begin
		term_out <= #1 want_term_in;
		fwd_out <= #1 want_fwd_in;
		bwd_out <= #1 want_bwd_in;
	end
endmodule // idec_contacts

// ### verif/idec_props.sv
/*
 Checker on the decoder top ports.
 Assumes one clock and fixed bus latencies.
*/
`timescale 1ns/1ns
module idec_props (
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	// Pins
	input wire logic [8:0] TERM_IN,
	input wire logic TRIP_IN,
	// Bus
	input wire logic S_AXI_AWVALID_IN,
	input wire logic S_AXI_AWREADY_OUT,
	input wire logic S_AXI_WVALID_IN,
	input wire logic S_AXI_WREADY_OUT,
	input wire logic [1:0] S_AXI_BRESP_OUT,
	input wire logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic S_AXI_ARVALID_IN,
	input wire logic S_AXI_ARREADY_OUT,
	input wire logic [31:0] S_AXI_RDATA_OUT,
	input wire logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	// Decoded outputs
	input wire logic [35:0] CMD_FLAGS_OUT,
	input wire logic [1:0] RAMP_SEL_OUT,
	input wire logic RUN_FORWARD_OUT,
	input wire logic RUN_BACKWARD_OUT,
	input wire logic OUTPUT_CUTOFF_OUT,
	input wire logic RESTART_START_FREQ_OUT,
	input wire logic ALARM_OUT,
	input wire logic TRIP_IND_OUT
);
	// One clock domain
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (RST_IN);

	// Flags trace back through sync and decode
	AST_FLAG_CAUSE: assert property (|CMD_FLAGS_OUT |-> |$past(TERM_IN, 3))
		else $error("command flag without a closed terminal");
	AST_RAMP_FOLLOW: assert property (RAMP_SEL_OUT == $past(CMD_FLAGS_OUT[5:4]))
		else $error("ramp select does not follow its flags");
	AST_COAST_CUT: assert property (CMD_FLAGS_OUT[7] |=> OUTPUT_CUTOFF_OUT)
		else $error("coast did not cut output");
	AST_COAST_NO_RUN: assert property (CMD_FLAGS_OUT[7] |=> !RUN_FORWARD_OUT && !RUN_BACKWARD_OUT)
		else $error("run shown during coast");
	AST_RESTART_CAUSE: assert property (RESTART_START_FREQ_OUT |->
		$past(CMD_FLAGS_OUT[7], 2) && !$past(CMD_FLAGS_OUT[7]) ##1 !RESTART_START_FREQ_OUT)
		else $error("restart pulse without coast release");
	AST_RUN_EXCL: assert property (!(RUN_FORWARD_OUT && RUN_BACKWARD_OUT))
		else $error("both run directions on");
	AST_TRIP_SETS: assert property (TRIP_IN |=> ALARM_OUT && TRIP_IND_OUT ##1 OUTPUT_CUTOFF_OUT)
		else $error("trip did not set alarm, indication and cutoff");
	AST_ALARM_HOLD: assert property (ALARM_OUT && !CMD_FLAGS_OUT[8] |=> ALARM_OUT)
		else $error("alarm dropped without reset input");
	AST_TRIP_HOLD: assert property (TRIP_IND_OUT && !CMD_FLAGS_OUT[8] && !$past(CMD_FLAGS_OUT[8])
		|=> TRIP_IND_OUT)
		else $error("trip indication dropped without reset release");
	AST_B_LATENCY: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN
		&& S_AXI_WREADY_OUT |=> S_AXI_BVALID_OUT)
		else $error("write response late");
	AST_B_STAND: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN
		|=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
		else $error("write response not held");
	AST_R_LATENCY: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT
		|=> !S_AXI_ARREADY_OUT ##1 S_AXI_RVALID_OUT)
		else $error("read data not two cycles after address");
	AST_R_STAND: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
		|=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
		else $error("read data not held");
endmodule // idec_props

bind idec_top idec_props u_props (.*);

// ### verif/idec_top_tb.sv
/*
 Self-checking bench of the decoder.
 Assumes the contact model and checker are compiled with it.
*/
`timescale 1ns/1ns
module idec_top_tb;
	import idec_pkg::*;
	// Clock, reset, pins and bus
	logic clk = 1'b0, rst = 1'b1, trip = 1'b0, want_fwd = 1'b0, want_bwd = 1'b0;
	logic [8:0] want_term = 9'h000;
	wire logic [8:0] term;
	wire logic run_forward, bwd;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, ramp;
	logic [31:0] rdata;
	logic [35:0] flags;
	logic [15:0] speed, pri_f, alt_f;
	logic [15:0] pre [1:15];
	logic run_f, run_b, cut, restart, alarm, trip_ind;
	int err_count = 0, tests_run = 0;

	// Free-running system clock
	initial begin
		forever #2 clk = ~clk;
	end

	idec_contacts u_contacts (.want_term_in(want_term), .want_fwd_in(want_fwd),
		.want_bwd_in(want_bwd), .term_out(term), .fwd_out(run_forward), .bwd_out(bwd));

	idec_top dut (.CLK_SYS_IN(clk), .RST_IN(rst), .TERM_IN(term), .RUN_FORWARD_IN(run_forward),
		.RUN_BACKWARD_IN(bwd), .TRIP_IN(trip), .S_AXI_AWADDR_IN(awaddr),
		.S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
		.S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
		.S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
		.S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
		.S_AXI_RREADY_IN(rready), .CMD_FLAGS_OUT(flags), .SPEED_REF_OUT(speed),
		.RAMP_SEL_OUT(ramp), .RUN_FORWARD_OUT(run_f), .RUN_BACKWARD_OUT(run_b),
		.OUTPUT_CUTOFF_OUT(cut), .RESTART_START_FREQ_OUT(restart), .ALARM_OUT(alarm),
		.TRIP_IND_OUT(trip_ind));

	// Verdict
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Compare and count
	task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// A bounded wait ran out
	task automatic hung(input string nm);
		err_count++;
		$display("[FAIL] %s expected answer seen none", nm);
		end_sim();
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One write, address and data together; bready stays up
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (n > 50) hung("write");
		end while (!bvalid);
		r = bresp;
	endtask
	// One read; rready stays up
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (n > 50) hung("read");
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask
	// Expected speed reference for a selector index and source switch state
	function automatic logic [15:0] exp_speed(input logic [3:0] idx, input logic use_alt);
		if (idx != 4'h0) return pre[idx];
		return use_alt ? alt_f : pri_f;
	endfunction

	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [8:0] v;
		int t;
		t = $urandom(22);
		ticks(12);
		rst <= 1'b0;
		ticks(3);
		rd(OFS_TERM_FUNC_LAST, d, r);
		chk("func reset", {26'h0, FUNC_RESET}, d);
		rd(8'h30, d, r);
		chk("unmapped rresp", RESP_SLVERR, r);
		wr(8'h30, 32'hFFFF_FFFF, 4'hF, r);
		chk("unmapped bresp", RESP_SLVERR, r);
		pri_f = 16'($urandom);
		alt_f = 16'($urandom);
		wr(OFS_PRIMARY_FREQ, {16'h0000, pri_f}, 4'hF, r);
		wr(OFS_ALT_FREQ, {16'h0000, alt_f}, 4'hF, r);
		for (int k = 1; k <= NUM_PRESET; k++) begin
			pre[k] = 16'($urandom);
			wr(OFS_PRESET_FIRST + 8'((k - 1) * 4), {16'h0000, pre[k]}, 4'hF, r);
		end
		// A preset write without both low strobes must leave the old value
		wr(OFS_PRESET_FIRST, 32'h0000_FFFF, 4'h2, r);
		rd(OFS_PRESET_FIRST, d, r);
		chk("preset keep", {16'h0000, pre[1]}, d);
		// Every code alone on a random terminal; unassigned terminals closed at random
		for (int c = 0; c < NUM_FUNC; c++) begin
			t = $urandom_range(8, 0);
			want_term <= 9'($urandom) | (9'h001 << t);
			ticks(4);
			wr(8'(t * 4), 32'(c), 4'hF, r);
			ticks(8);
			chk("flags", 36'h000000001 << c, flags);
			wr(8'(t * 4), {26'h0, FUNC_RESET}, 4'hF, r);
		end
		// Preset bits, ramp bits, source switch and one code on two terminals
		for (int k = 0; k < 9; k++) begin
			wr(8'(k * 4), (k < 6) ? 32'(k) : (k == 6) ? 32'h0000_000B : 32'h0000_0014, 4'hF, r);
		end
		for (int i = 0; i < 40; i++) begin
			v = (i == 0) ? 9'h000 : (i == 1) ? 9'h00F : 9'($urandom);
			want_term <= v;
			ticks(8);
			chk("speed", exp_speed(v[3:0], v[6]), speed);
			chk("ramp", v[5:4], ramp);
			chk("shared", v[7] | v[8], flags[20]);
		end
		// Self-hold on terminal 1, coast on 2, alarm reset on 3
		for (int k = 0; k < 9; k++) begin
			wr(8'(k * 4), (k < 3) ? 32'(k + 6) : {26'h0, FUNC_RESET}, 4'hF, r);
		end
		want_term <= 9'h001;
		want_fwd <= 1'b1;
		ticks(8);
		want_fwd <= 1'b0;
		ticks(8);
		chk("held run", 1'b1, run_f);
		want_term <= 9'h003;
		ticks(8);
		chk("coast", 3'b100, {cut, run_f, alarm});
		want_term <= 9'h001;
		t = 0;
		repeat (10) begin
			@(posedge clk);
			if (restart === 1'b1) t++;
		end
		chk("restart pulses", 1, t);
		chk("resumed", 2'b10, {run_f, cut});
		want_term <= 9'h000;
		ticks(8);
		chk("hold released", 1'b0, run_f);
		want_bwd <= 1'b1;
		ticks(8);
		chk("bwd run", 2'b01, {run_f, run_b});
		want_bwd <= 1'b0;
		// Trip, then alarm reset pressed and released
		trip <= 1'b1;
		@(posedge clk);
		trip <= 1'b0;
		ticks(3);
		chk("tripped", 2'b11, {alarm, trip_ind});
		want_term <= 9'h004;
		ticks(8);
		chk("alarm cleared", 2'b01, {alarm, trip_ind});
		want_term <= 9'h000;
		ticks(8);
		chk("trip cleared", 2'b00, {alarm, trip_ind});
		end_sim();
	end
endmodule // idec_top_tb
